/* File: rtl/decoder_pkg.sv */
// Shared constants and types for the instruction field decoder.
package decoder_pkg;
	typedef enum logic [1:0] {
		size_byte   = 2'b00,
		size_word   = 2'b01,
		size_double = 2'b11
	} operand_size_type;

	typedef enum logic [1:0] {
		match_none  = 2'b00,
		match_while = 2'b01,
		match_until = 2'b11
	} match_mode_type;

	// Format numbers as presented by the loader.
	localparam logic [4:0] FMT_COND_BRANCH = 5'h00;
	localparam logic [4:0] FMT_SHORT       = 5'h02;
	localparam logic [4:0] FMT_JUMP        = 5'h03;
	localparam logic [4:0] FMT_STRING      = 5'h05;
	localparam logic [4:0] FMT_UNDEF_A     = 5'h0a;
	localparam logic [4:0] FMT_FLOAT       = 5'h0b;
	localparam logic [4:0] FMT_FLOAT_EXT   = 5'h0c;
	localparam logic [4:0] FMT_UNDEF_B     = 5'h0d;
	localparam logic [4:0] FMT_TRANSLATION = 5'h0e;
	localparam logic [4:0] FMT_CUSTOM      = 5'h0f;
	localparam logic [4:0] FMT_UNDEF_C     = 5'h10;
	localparam logic [4:0] FMT_UNDEF_D     = 5'h11;

	// Field positions inside the 24-bit opcode window.
	localparam int SIZE_LSB     = 0;
	localparam int COND_LSB     = 4;
	localparam int SHORT_OP_LSB = 4;
	localparam int SHORT_LSB    = 7;
	localparam int JUMP_OP_LSB  = 7;
	localparam int GEN1_LSB     = 11;
	localparam int GEN2_LSB     = 6;
	localparam int EXT_OP_LSB   = 10;
	localparam int EXT_SHORT_LSB = 15;
	localparam int FP_TYPE_BIT  = 8;
	localparam int REG_LSB      = 11;
	localparam int MATCH_LSB    = 16;
	localparam int BACKWARD_BIT = 15;
	localparam int TRANSL_BIT   = 18;

	// Short-format operations, then the translation-register and reserved jump opcodes.
	localparam logic [2:0] OP_ADD_SHORT  = 3'b000;
	localparam logic [2:0] OP_CMP_SHORT  = 3'b001;
	localparam logic [2:0] OP_STORE_DED  = 3'b010;
	localparam logic [2:0] OP_SET_COND   = 3'b011;
	localparam logic [2:0] OP_ADD_CMP_BR = 3'b100;
	localparam logic [2:0] OP_MOVE_SHORT = 3'b101;
	localparam logic [2:0] OP_LOAD_DED   = 3'b110;
	localparam logic [3:0] OP_LOAD_XLAT  = 4'b0010;
	localparam logic [3:0] OP_STORE_XLAT = 4'b0011;
	localparam logic [3:0] OP_JUMP_BAD   = 4'b1000;

	// Selector limits and the fixed condition codes.
	localparam logic [3:0] DED_RSVD_LO   = 4'b0101;
	localparam logic [3:0] DED_RSVD_HI   = 4'b0111;
	localparam logic [3:0] DED_MODULE    = 4'b1111;
	localparam logic [3:0] XLAT_FIRST    = 4'b1001;
	localparam logic [3:0] COND_ALWAYS   = 4'b1110;
	localparam logic [3:0] COND_NEVER    = 4'b1111;
endpackage : decoder_pkg

/* File: rtl/instruction_field_decoder.sv */
// Instruction field decoder: operand types, conditions, short immediates, selectors and trap detection.
`timescale 1ns/10ps
module instruction_field_decoder #(
	parameter int IMM_WIDTH = 32
) (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic                          instr_valid,
	input  wire logic [4:0]                    instr_format,
	input  wire logic [23:0]                   instr_bits,
	input  wire logic                          flag_z,
	input  wire logic                          flag_c,
	input  wire logic                          flag_l,
	input  wire logic                          flag_n,
	input  wire logic                          flag_f,
	output logic                               decode_valid,
	output logic                               dispatch,
	output logic                               undefined_instruction_trap,
	output decoder_pkg::operand_size_type      operand_size,
	output logic                               float_standard,
	output logic                               custom_double,
	output logic                               cond_true,
	output logic [IMM_WIDTH-1:0]               short_immediate,
	output logic [3:0]                         dedicated_select,
	output logic [2:0]                         translation_select,
	output logic                               string_translated,
	output logic                               string_backward,
	output decoder_pkg::match_mode_type        match_mode,
	output logic [2:0]                         register_select,
	output logic [4:0]                         gen_first,
	output logic [4:0]                         gen_second
);
	import decoder_pkg::*;

	// A narrower immediate could not carry the signed short value, so elaboration stops here.
	if (IMM_WIDTH < 4) begin : g_width_check
		$error("IMM_WIDTH must hold at least the 4-bit short field");
	end

	wire [1:0] size_field  = instr_bits[SIZE_LSB +: 2];
	wire [3:0] short_field = instr_bits[SHORT_LSB +: 4];
	wire [2:0] short_op    = instr_bits[SHORT_OP_LSB +: 3];
	wire [3:0] jump_op     = instr_bits[JUMP_OP_LSB +: 4];
	wire [3:0] ext_op      = instr_bits[EXT_OP_LSB +: 4];
	wire [3:0] ext_short   = instr_bits[EXT_SHORT_LSB +: 4];

	wire is_short    = instr_format == FMT_SHORT;
	wire is_jump     = instr_format == FMT_JUMP;
	wire is_string   = instr_format == FMT_STRING;
	wire is_xlat     = instr_format == FMT_TRANSLATION;
	wire is_float    = (instr_format == FMT_FLOAT) || (instr_format == FMT_FLOAT_EXT);
	wire is_custom   = instr_format == FMT_CUSTOM;
	wire is_set_cond = is_short && (short_op == OP_SET_COND);
	wire is_ded      = is_short && ((short_op == OP_LOAD_DED) || (short_op == OP_STORE_DED));
	wire is_xlat_reg = is_xlat && ((ext_op == OP_LOAD_XLAT) || (ext_op == OP_STORE_XLAT));
	wire is_quick    = is_short && ((short_op == OP_ADD_SHORT) || (short_op == OP_CMP_SHORT) ||
		(short_op == OP_ADD_CMP_BR) || (short_op == OP_MOVE_SHORT));

	// Set-on-condition carries its code in the short field; branches carry it in the low opcode byte.
	wire [3:0] cond_code = is_set_cond ? short_field : instr_bits[COND_LSB +: 4];

	function automatic logic cond_eval(input logic [3:0] code, input logic z, input logic c,
		input logic l, input logic n, input logic f);
		logic result;
		result = 1'b0;
		unique case (code)
			4'h0: result = z;
			4'h1: result = !z;
			4'h2: result = c;
			4'h3: result = !c;
			4'h4: result = l;
			4'h5: result = !l;
			4'h6: result = n;
			4'h7: result = !n;
			4'h8: result = f;
			4'h9: result = !f;
			4'ha: result = !l && !z;
			4'hb: result = l || z;
			4'hc: result = !n && !z;
			4'hd: result = n || z;
			4'he: result = 1'b1;
			4'hf: result = 1'b0;
		endcase
		return result;
	endfunction : cond_eval

	wire next_cond_true = cond_eval(cond_code, flag_z, flag_c, flag_l, flag_n, flag_f);

	// Trap sources; each one blocks dispatch below.
	wire ded_reserved  = is_ded && (short_field >= DED_RSVD_LO) && (short_field <= DED_RSVD_HI);
	wire xlat_bad      = is_xlat_reg && (ext_short < XLAT_FIRST);
	wire jump_bad      = is_jump && (jump_op[0] || (jump_op == OP_JUMP_BAD));
	wire string_bad    = is_string && (ext_op[3] || (ext_op[3:2] == 2'b01));
	wire size_bad      = (is_short || is_jump || is_string) && (size_field == 2'b10);
	wire format_bad    = (instr_format == FMT_UNDEF_A) || (instr_format == FMT_UNDEF_B) ||
		(instr_format == FMT_UNDEF_C) || (instr_format == FMT_UNDEF_D);
	wire next_trap     = ded_reserved || xlat_bad || jump_bad || string_bad || size_bad || format_bad;

	wire [IMM_WIDTH-1:0] next_imm = is_quick ?
		{{(IMM_WIDTH-4){short_field[3]}}, short_field} : '0;
	// A slot that is not a valid translation register access keeps the selector index zero; the trap path covers codes below 1001.
	wire [2:0] next_xlat_sel = is_xlat_reg && !xlat_bad ? 3'(ext_short - XLAT_FIRST) : 3'h0;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			decode_valid <= 1'b0;
			dispatch <= 1'b0;
			undefined_instruction_trap <= 1'b0;
		end else begin
			decode_valid <= instr_valid;
			undefined_instruction_trap <= instr_valid && next_trap;
			dispatch <= instr_valid && !next_trap;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			operand_size <= size_byte;
			float_standard <= 1'b0;
			custom_double <= 1'b0;
			cond_true <= 1'b0;
			short_immediate <= '0;
			dedicated_select <= 4'h0;
			translation_select <= 3'h0;
			string_translated <= 1'b0;
			string_backward <= 1'b0;
			match_mode <= match_none;
			register_select <= 3'h0;
			gen_first <= 5'h00;
			gen_second <= 5'h00;
		end else if (instr_valid) begin
			operand_size <= operand_size_type'(size_field);
			float_standard <= is_float && instr_bits[FP_TYPE_BIT];
			custom_double <= is_custom && instr_bits[FP_TYPE_BIT];
			cond_true <= next_cond_true;
			short_immediate <= next_imm;
			dedicated_select <= is_ded ? short_field : 4'h0;
			translation_select <= next_xlat_sel;
			string_translated <= is_string && instr_bits[TRANSL_BIT];
			string_backward <= is_string && instr_bits[BACKWARD_BIT];
			match_mode <= is_string ? match_mode_type'(instr_bits[MATCH_LSB +: 2]) : match_none;
			register_select <= instr_bits[REG_LSB +: 3];
			gen_first <= instr_bits[GEN1_LSB +: 5];
			gen_second <= instr_bits[GEN2_LSB +: 5];
		end
	end

	sequence trapped_s;
		undefined_instruction_trap && decode_valid;
	endsequence

	sequence dispatched_s;
		decode_valid && dispatch && !undefined_instruction_trap;
	endsequence

	trap_blocks_dispatch_a: assert property (@(posedge clk) disable iff (!reset_n)
		trapped_s |-> !dispatch) else $error("trapped instruction was dispatched");
	every_valid_decided_a: assert property (@(posedge clk) disable iff (!reset_n)
		decode_valid |-> (dispatch ^ undefined_instruction_trap)) else $error("valid slot neither traps nor dispatches");
	jump_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_jump && jump_op[0]) |=> trapped_s) else $error("odd jump opcode did not trap");
	string_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_string && ext_op[3]) |=> trapped_s) else $error("high string opcode did not trap");
	xlat_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_xlat_reg && !ext_short[3]) |=> trapped_s) else $error("low translation selector did not trap");
	ded_reserved_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_ded && (short_field == 4'h6)) |=> trapped_s) else $error("reserved dedicated code did not trap");
	cond_fixed_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && !is_set_cond && (instr_bits[COND_LSB +: 4] == COND_NEVER)) |=> !cond_true)
		else $error("never condition evaluated true");
	cond_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && !is_set_cond && (instr_bits[COND_LSB +: 4] == 4'h0)) |=> (cond_true == $past(flag_z)))
		else $error("equal condition does not follow Z");
	quick_sign_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_quick) |=> (short_immediate[IMM_WIDTH-1] == $past(short_field[3])))
		else $error("short immediate not sign extended");

	// The loader may issue every cycle, so a lost answer would silently drop an instruction.
	slot_answered_a: assert property (@(posedge clk) disable iff (!reset_n)
		instr_valid |=> decode_valid)
		else $error("accepted slot produced no answer");
	jump_reserved_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_jump && (jump_op == OP_JUMP_BAD)) |=> trapped_s)
		else $error("reserved jump opcode did not trap");
	string_mid_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_string && (ext_op[3:2] == 2'b01)) |=> trapped_s)
		else $error("string opcode with top bits 01 did not trap");
	format_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && format_bad) |=> trapped_s)
		else $error("undefined format did not trap");
	// An illegal size code traps first, so the module selector dispatch check leaves it out of its antecedent.
	ded_module_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_ded && (short_field == DED_MODULE) && (size_field != 2'b10)) |=> dispatched_s)
		else $error("module register selector did not dispatch");
	ded_select_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_ded && (short_field == DED_MODULE)) |=> (dedicated_select == DED_MODULE))
		else $error("module register selector not forwarded");
	xlat_select_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_xlat_reg && (ext_short >= XLAT_FIRST)) |=> dispatched_s)
		else $error("valid translation selector did not dispatch");
	cond_always_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && !is_set_cond && (instr_bits[COND_LSB +: 4] == COND_ALWAYS)) |=> cond_true)
		else $error("always condition evaluated false");
	set_cond_never_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && is_set_cond && (short_field == COND_NEVER)) |=> !cond_true)
		else $error("set-on-condition never code evaluated true");
	size_word_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && (size_field == 2'b01)) |=> (operand_size == size_word))
		else $error("word size code not decoded as word");
	match_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
		(instr_valid && !is_string) |=> (match_mode == match_none))
		else $error("match mode set outside the string format");
endmodule : instruction_field_decoder

/* File: verification/instruction_field_decoder_tb_top.sv */
// Self-checking bench for the instruction field decoder.
`timescale 1ns/10ps
module instruction_field_decoder_tb_top;
	import decoder_pkg::*;
	logic                  clk = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  instr_valid, decode_valid, dispatch, undefined_instruction_trap, float_standard;
	logic                  custom_double, cond_true, string_translated, string_backward;
	logic [4:0]            instr_format, flags, gen_first, gen_second;
	logic [23:0]           instr_bits;
	logic [31:0]           short_immediate;
	logic [3:0]            dedicated_select;
	logic [2:0]            translation_select, register_select;
	operand_size_type      operand_size;
	match_mode_type        match_mode;
	int                    mismatches = 0;
	int                    compares = 0;
	always #20 clk = ~clk;
	slot_source u_slot_source (.clk, .instr_valid, .instr_format, .instr_bits, .flags);
	instruction_field_decoder u_instruction_field_decoder (.clk, .reset_n, .instr_valid, .instr_format,
		.instr_bits, .flag_z(flags[4]), .flag_c(flags[3]), .flag_l(flags[2]), .flag_n(flags[1]),
		.flag_f(flags[0]), .decode_valid, .dispatch, .undefined_instruction_trap, .operand_size,
		.float_standard, .custom_double, .cond_true, .short_immediate, .dedicated_select,
		.translation_select, .string_translated, .string_backward, .match_mode, .register_select,
		.gen_first, .gen_second);
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic slot(input logic [4:0] fmt, input logic [23:0] bits, input logic [4:0] flg, input logic trap);
		u_slot_source.send(fmt, bits, flg);
		chk("decode_valid", 32'(decode_valid), 32'h1);
		chk("trap", 32'(undefined_instruction_trap), 32'(trap));
		chk("dispatch", 32'(dispatch), 32'(!trap));
	endtask : slot
	function automatic logic cond_exp(input logic [3:0] c, input logic [4:0] f);
		logic z, cy, l, n, g;
		{z, cy, l, n, g} = f;
		case (c)
			4'h0: return z;
			4'h1: return !z;
			4'h2: return cy;
			4'h3: return !cy;
			4'h4: return l;
			4'h5: return !l;
			4'h6: return n;
			4'h7: return !n;
			4'h8: return g;
			4'h9: return !g;
			4'ha: return !l && !z;
			4'hb: return l || z;
			4'hc: return !n && !z;
			4'hd: return n || z;
			4'he: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : cond_exp
	task automatic test_cond();
		for (int c = 0; c < 16; c++) begin
			for (int f = 0; f < 32; f++) begin
				slot(FMT_COND_BRANCH, {16'h0000, 4'(c), 4'h0}, 5'(f), 1'b0);
				chk("branch cond", 32'(cond_true), 32'(cond_exp(4'(c), 5'(f))));
				slot(FMT_SHORT, {13'h0000, 4'(c), OP_SET_COND, 4'h3}, 5'(f), 1'b0);
				chk("set cond", 32'(cond_true), 32'(cond_exp(4'(c), 5'(f))));
			end
		end
	endtask : test_cond
	task automatic test_types();
		logic [1:0] sizes[3] = '{2'b00, 2'b01, 2'b11};
		foreach (sizes[i]) begin
			slot(5'h04, {22'h000000, sizes[i]}, 5'h00, 1'b0);
			chk("operand_size", 32'(operand_size), 32'(sizes[i]));
		end
		slot(FMT_SHORT, 24'h000002, 5'h00, 1'b1);
		slot(FMT_JUMP, 24'h000002, 5'h00, 1'b1);
		slot(FMT_STRING, 24'h000002, 5'h00, 1'b1);
		for (int b = 0; b < 2; b++) begin
			slot(FMT_FLOAT, 24'(b) << FP_TYPE_BIT, 5'h00, 1'b0);
			chk("float_standard", 32'(float_standard), 32'(b));
			slot(FMT_FLOAT_EXT, 24'(b) << FP_TYPE_BIT, 5'h00, 1'b0);
			chk("float_ext_standard", 32'(float_standard), 32'(b));
			slot(FMT_CUSTOM, 24'(b) << FP_TYPE_BIT, 5'h00, 1'b0);
			chk("custom_double", 32'(custom_double), 32'(b));
		end
		slot(FMT_UNDEF_A, 24'h000000, 5'h00, 1'b1);
		slot(FMT_UNDEF_B, 24'h000000, 5'h00, 1'b1);
		slot(FMT_UNDEF_C, 24'h000000, 5'h00, 1'b1);
		slot(FMT_UNDEF_D, 24'h000000, 5'h00, 1'b1);
	endtask : test_types
	task automatic test_short();
		logic [2:0] ops[4] = '{OP_ADD_SHORT, OP_CMP_SHORT, OP_ADD_CMP_BR, OP_MOVE_SHORT};
		foreach (ops[i]) begin
			for (int s = 0; s < 16; s++) begin
				slot(FMT_SHORT, {13'h0000, 4'(s), ops[i], 4'h3}, 5'h00, 1'b0);
				chk("short_immediate", short_immediate, {{28{s[3]}}, 4'(s)});
			end
		end
	endtask : test_short
	task automatic test_selectors();
		for (int c = 0; c < 16; c++) begin
			slot(FMT_SHORT, {13'h0000, 4'(c), OP_LOAD_DED, 4'h3}, 5'h00, c >= 5 && c <= 7);
			if (c < 5 || c > 7) chk("load dedicated_select", 32'(dedicated_select), 32'(c));
			slot(FMT_SHORT, {13'h0000, 4'(c), OP_STORE_DED, 4'h3}, 5'h00, c >= 5 && c <= 7);
			if (c < 5 || c > 7) chk("store dedicated_select", 32'(dedicated_select), 32'(c));
			slot(FMT_TRANSLATION, {5'h00, 4'(c), 1'b0, OP_LOAD_XLAT, 10'h000}, 5'h00, c <= 8);
			if (c > 8) chk("translation_select", 32'(translation_select), 32'(c - 9));
			slot(FMT_TRANSLATION, {5'h00, 4'(c), 1'b0, OP_STORE_XLAT, 10'h000}, 5'h00, c <= 8);
		end
	endtask : test_selectors
	task automatic test_jump_string();
		logic [1:0] m;
		for (int op = 0; op < 16; op++) begin
			slot(FMT_JUMP, {13'h0000, 4'(op), 7'h03}, 5'h00, op[0] || op == 8);
			m = (op % 3 == 0) ? 2'b00 : (op % 3 == 1) ? 2'b01 : 2'b11;
			slot(FMT_STRING, {5'h00, op[0], m, op[1], 1'b0, 4'(op), 10'h003}, 5'h00, op[3] || op[3:2] == 2'b01);
			if (op < 4) begin
				chk("string_translated", 32'(string_translated), 32'(op[0]));
				chk("string_backward", 32'(string_backward), 32'(op[1]));
				chk("match_mode", 32'(match_mode), 32'(m));
			end
		end
		slot(5'h04, 24'h00b5c7, 5'h00, 1'b0);
		chk("register_select", 32'(register_select), 32'h6);
		chk("gen_first", 32'(gen_first), 32'h16);
		chk("gen_second", 32'(gen_second), 32'h17);
	endtask : test_jump_string
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin
		#(40 * 20000);
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		test_cond();
		test_types();
		test_short();
		test_selectors();
		test_jump_string();
		print_verdict();
	end
endmodule : instruction_field_decoder_tb_top

/* File: verification/slot_source.sv */
// Loader model that hands the decoder one instruction slot at a time.
`timescale 1ns/10ps
module slot_source (
	input  wire logic        clk,
	output logic             instr_valid,
	output logic [4:0]       instr_format,
	output logic [23:0]      instr_bits,
	output logic [4:0]       flags
);
	initial begin
		instr_valid = 1'b0;
		instr_format = 5'h00;
		instr_bits = 24'h000000;
		flags = 5'h00;
	end
	task automatic send(input logic [4:0] fmt, input logic [23:0] bits, input logic [4:0] flg);
		@(posedge clk);
		#1;
		instr_valid = 1'b1;
		instr_format = fmt;
		instr_bits = bits;
		flags = flg;
		@(posedge clk);
		#1;
		instr_valid = 1'b0;
		// Idle slots show the inverse of the bits and flags so neither can pass for fresh data; the format is held.
		instr_bits = ~bits;
		flags = ~flg;
	endtask : send
endmodule : slot_source
